// ---- core/pam_debounce.sv ----
// Input filter: accepts a level stable over two debouncer clock edges.
// Assumes tick_i is a one-cycle pulse at each debouncer clock rise.
`timescale 1ns/100ps
`default_nettype none
module pam_debounce (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic resetn_i,
   // Debouncer tick, raw level and filtered level
   input wire logic tick_i,
   input wire logic d_i,
   output logic q_o
);
   logic last_reg;
   logic moved_reg;

   // A change between ticks spoils the next acceptance.
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         last_reg <= 1'b0;
         moved_reg <= 1'b0;
         q_o <= 1'b0;
      end
      else if (tick_i)
      begin
         if (d_i == last_reg && !moved_reg)
            q_o <= d_i;
         last_reg <= d_i;
         moved_reg <= 1'b0;
      end
      else if (d_i != last_reg)
         moved_reg <= 1'b1;
   end
endmodule
`default_nettype wire

// ---- core/pam_pad_drv.sv ----
// Pad stage: turns value, enable and drive style into pin signals.
// Assumes the core holds every request in flip-flops.
`timescale 1ns/100ps
`default_nettype none
module pam_pad_drv (
   // Requests from the core
   pam_pad_if.pad pad,
   // Pin side
   output logic [5:0] line_o,
   output logic [5:0] line_oe_o,
   output logic [5:0] pullup_o,
   output logic [5:0] pulldown_o
);
   // Open drain drives only the low level; a high is left to the pull-up.
   always_comb
   begin
      line_o = pad.val & ~pad.od;
      line_oe_o = pad.oe & ~(pad.od & pad.val);
   end

   // Pulls stay off while the line is a defined output; never both on.
   always_comb
   begin
      pullup_o = pad.od & (~pad.oe | pad.val);
      pulldown_o = ~pad.pd_off & ~pad.od & ~pad.oe;
   end
endmodule
`default_nettype wire

// ---- core/pam_pad_if.sv ----
// Per-line drive request passed from the port core to the pad stage.
// Assumes one clock domain; all members are flop-driven by the core.
`timescale 1ns/100ps
`default_nettype none
interface pam_pad_if;
   logic [5:0] val;
   logic [5:0] oe;
   logic [5:0] od;
   logic [5:0] pd_off;
   modport drv (output val, output oe, output od, output pd_off);
   modport pad (input val, input oe, input od, input pd_off);
endinterface
`default_nettype wire

// ---- core/pam_pkg.sv ----
// Constants shared by the six-line port: register byte addresses, bit
// positions, reset values and the line-2 output source selections.
// Assumes a 32-bit classic Wishbone slave with 4-bit data in the low nibble.
package pam_pkg;
   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [7:0] ADR_PIN_VALUE = 8'h00;
   localparam logic [7:0] ADR_DRIVE_EN = 8'h04;
   localparam logic [7:0] ADR_PULLDOWN_OFF = 8'h08;
   localparam logic [7:0] ADR_OPEN_DRAIN = 8'h0c;
   localparam logic [7:0] ADR_UPPER_LINES = 8'h10;
   localparam logic [7:0] ADR_FREQ_RESET = 8'h14;
   localparam logic [7:0] ADR_OUT_SEL_FIRST = 8'h18;
   localparam logic [7:0] ADR_OUT_SEL_SECOND = 8'h1c;
   localparam logic [7:0] ADR_WAKE_CTRL = 8'h20;
   localparam logic [7:0] ADR_POWER_CTRL = 8'h24;
   // ------------------------------------------------------------
   // Bit positions
   // ------------------------------------------------------------
   localparam int B_OD5 = 3;
   localparam int B_OE5 = 2;
   localparam int B_DATA5 = 1;
   localparam int B_ACT_RESET_EN = 3;
   localparam int B_EXT_RESET_EN = 2;
   localparam int B_SER_STATUS3 = 3;
   localparam int B_SER_CLOCK1 = 2;
   localparam int B_PWM1 = 1;
   localparam int B_PWM0 = 0;
   localparam int B_NOPD5 = 3;
   localparam int B_FREQ5 = 2;
   localparam int B_WAKE34 = 3;
   localparam int B_WAKE05 = 2;
   localparam int B_PICK34 = 1;
   localparam int B_PICK05 = 0;
   localparam int B_SLEEP = 0;
   localparam int B_VCHECK = 1;
   localparam int B_NOPULL4 = 2;
   // ------------------------------------------------------------
   // Reset values and frequency select codes
   // ------------------------------------------------------------
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [3:0] RST_OUT_SEL_SECOND = 4'h3;
   localparam logic [1:0] FS_CORE = 2'h3;
   localparam logic [1:0] FS_SYSTEM = 2'h2;
   localparam logic [1:0] FS_2KHZ = 2'h1;
   // Line-2 source, in the order of its two select bits.
   typedef enum logic [1:0] {L2_DATA, L2_FREQ, L2_SOUT, L2_RSTIND} pam_l2sel_t;
endpackage

// ---- core/pam_port_a_io_mux.sv ----
// Six-line general-purpose port: registers, input blocking, wake-up on
// change, external reset pick, and output multiplexing of each line except input-only line 4.
// Assumes pin levels and source signals are synchronous to mclk_i.
// resetn_i is the power-on reset; sys_reset_i is any other system reset.
//
// Contract
// - In sleep, a change on a wake-enabled paired input leaves sleep at once.
// - In serial slave mode line 0 is data in, line 1 clock in.
// - Debounced rising pulse on picked line resets only with both enables set.
// - Reset source is line 3 when pick bit is 0, line 4 when 1.
// - Voltage check enable routes line 4 to the level detector.
// - While routed, a read of line 4 returns 0.
// - Power-on reset clears control registers: pull-ups off, pull-downs on (the second output select resets to 3).
// - Registers hold through sleep; any reset ends sleep.
// - Other resets keep power-on-only bits, reinitialise the rest.
// - After any reset lines 0 to 3 are tri-stated.
// - Lines 0, 3, 4 block in sleep unless used for wake or interrupt (line 3 or 4 also stays live when picked as the enabled reset pin).
// - Lines 1 and 2 block whenever the sleep bit is set.
// - Line 4 also blocks during voltage check; line 5 never blocks.
// - CMOS drives both levels; open drain drives only low.
// - Pulls are off while a line is a defined output.
// - Drive enable makes a line an output; reads give pin level.
// - In system reset, line 2 is forced output under the strap pattern while line 2 is set to the reset indicator.
// - Every reset clears the line 2 drive enable.
// - Frequency select: 11 core, 10 system, 01 2 kHz, 00 1 Hz.
// - Line 0 output is general value or counter PWM by its select.
// - Core clock is RC clock, or line 1 when external clock used.
// - Open-drain bits reset only at power-on, default CMOS.
// - Pull-down off bits remove pull-down; cleared only at power-on (line 4's bit is in power control and clears on every reset).
// - Line 1 output: serial clock, else PWM or general value.
// - Line 2 output: general, frequency, serial data or reset indicator.
// - Line 3 output: serial status when selected, else general value.
// - Debounced inputs accept only after two stable debouncer edges.
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module pam_port_a_io_mux (
   // Clock and resets
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic sys_reset_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Pins
   input wire logic [5:0] line_i,
   output logic [5:0] line_o,
   output logic [5:0] line_oe_o,
   output logic [5:0] pullup_o,
   output logic [5:0] pulldown_o,
   // Peripheral sources and sinks
   input wire logic deb_tick_i,
   input wire logic [1:0] irq_en_i,
   input wire logic ser_master_i,
   input wire logic ser_dout_i,
   input wire logic ser_sclk_i,
   input wire logic ser_status_i,
   input wire logic pwm_i,
   input wire logic rc_clk_i,
   input wire logic ext_clk_sel_i,
   input wire logic sys_clk_i,
   input wire logic clk_2khz_i,
   input wire logic clk_1hz_i,
   input wire logic clk_8khz_i,
   output logic [5:0] line_in_o,
   output logic [5:0] blocked_o,
   output logic ser_din_o,
   output logic ser_sclk_o,
   output logic test_var1_o,
   output logic test_var2_o,
   output logic detector_route_o,
   output logic ext_reset_o,
   output logic sleep_o,
   output logic wake_o
);
   import pam_pkg::*;

   logic [3:0] data_reg;
   logic [3:0] oe_reg;
   logic [3:0] nopd_reg;
   logic [3:0] od_reg;
   logic od5_reg;
   logic oe5_reg;
   logic data5_reg;
   logic [3:0] frq_reg;
   logic [3:0] sel3_reg;
   logic [3:0] sel4_reg;
   logic [3:0] wake_reg;
   logic [2:1] pwr_reg;
   logic sleep_reg;
   logic [5:0] prev_reg;
   logic q34_prev_reg;
   logic ext_rst_reg;
   logic wake_reg_p;
   logic [31:0] rd_next;
   logic [5:0] val_next;
   logic [5:0] oe_next;
   logic wr;
   logic sys_rst;
   logic src05;
   logic src34;
   logic ch05;
   logic ch34;
   logic wake_hit;
   logic q05;
   logic q34;
   logic core_clk;
   logic freq_sig;
   logic force2;
   logic used0;
   logic used3;
   logic used4;
   pam_l2sel_t l2sel;
   pam_pad_if pad_bus ();

   // ------------------------------------------------------------
   // Bus slave
   // ------------------------------------------------------------

   // Writes land once, on the cycle the acknowledge is raised.
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
   // Any reset other than power-on: the system reset or our own pin reset.
   assign sys_rst = sys_reset_i || ext_rst_reg;

   // Single-wait acknowledge; unmapped addresses still answer with zero.
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end
      else
      begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i)
            wb_dat_o <= rd_next;
      end
   end

   // Read mux; pin values show the gated terminal level, not the latch.
   always_comb
   begin
      rd_next = 32'h0000_0000;
      if (wb_adr_i == ADR_PIN_VALUE)
         rd_next[3:0] = line_in_o[3:0];
      else if (wb_adr_i == ADR_DRIVE_EN)
         rd_next[3:0] = oe_reg;
      else if (wb_adr_i == ADR_PULLDOWN_OFF)
         rd_next[3:0] = nopd_reg;
      else if (wb_adr_i == ADR_OPEN_DRAIN)
         rd_next[3:0] = od_reg;
      else if (wb_adr_i == ADR_UPPER_LINES)
         rd_next[3:0] = {od5_reg, oe5_reg, line_in_o[5], line_in_o[4]};
      else if (wb_adr_i == ADR_FREQ_RESET)
         rd_next[3:0] = frq_reg;
      else if (wb_adr_i == ADR_OUT_SEL_FIRST)
         rd_next[3:0] = sel3_reg;
      else if (wb_adr_i == ADR_OUT_SEL_SECOND)
         rd_next[3:0] = sel4_reg;
      else if (wb_adr_i == ADR_WAKE_CTRL)
         rd_next[3:0] = wake_reg;
      else if (wb_adr_i == ADR_POWER_CTRL)
         rd_next[3:0] = {1'b0, pwr_reg, sleep_reg};
   end

   // ------------------------------------------------------------
   // Power-on-only registers
   // ------------------------------------------------------------

   // Pull settings other than line 4's, drive style and frequency settings survive system resets.
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         nopd_reg <= RST_NIBBLE;
         od_reg <= RST_NIBBLE;
         od5_reg <= 1'b0;
         frq_reg <= RST_NIBBLE;
         sel4_reg <= RST_OUT_SEL_SECOND;
      end
      else if (wr)
      begin
         if (wb_adr_i == ADR_PULLDOWN_OFF)
            nopd_reg <= wb_dat_i[3:0];
         if (wb_adr_i == ADR_OPEN_DRAIN)
            od_reg <= wb_dat_i[3:0];
         if (wb_adr_i == ADR_UPPER_LINES)
            od5_reg <= wb_dat_i[B_OD5];
         if (wb_adr_i == ADR_FREQ_RESET)
            frq_reg <= wb_dat_i[3:0];
         if (wb_adr_i == ADR_OUT_SEL_SECOND)
            sel4_reg <= wb_dat_i[3:0];
      end
   end

   // ------------------------------------------------------------
   // System registers
   // ------------------------------------------------------------

   // Every reset clears these, so lines 0 to 3 come back as inputs.
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         data_reg <= RST_NIBBLE;
         oe_reg <= RST_NIBBLE;
         oe5_reg <= 1'b0;
         data5_reg <= 1'b0;
         sel3_reg <= RST_NIBBLE;
         wake_reg <= RST_NIBBLE;
         pwr_reg <= 2'h0;
      end
      else if (sys_rst)
      begin
         data_reg <= RST_NIBBLE;
         oe_reg <= RST_NIBBLE;
         oe5_reg <= 1'b0;
         data5_reg <= 1'b0;
         sel3_reg <= RST_NIBBLE;
         wake_reg <= RST_NIBBLE;
         pwr_reg <= 2'h0;
      end
      else if (wr)
      begin
         if (wb_adr_i == ADR_PIN_VALUE)
            data_reg <= wb_dat_i[3:0];
         if (wb_adr_i == ADR_DRIVE_EN)
            oe_reg <= wb_dat_i[3:0];
         if (wb_adr_i == ADR_UPPER_LINES)
         begin
            oe5_reg <= wb_dat_i[B_OE5];
            data5_reg <= wb_dat_i[B_DATA5];
         end
         if (wb_adr_i == ADR_OUT_SEL_FIRST)
            sel3_reg <= wb_dat_i[3:0];
         if (wb_adr_i == ADR_WAKE_CTRL)
            wake_reg <= wb_dat_i[3:0];
         if (wb_adr_i == ADR_POWER_CTRL)
            pwr_reg <= wb_dat_i[B_NOPULL4:B_VCHECK];
      end
   end

   // ------------------------------------------------------------
   // Sleep and wake-up on change
   // ------------------------------------------------------------

   assign src05 = wake_reg[B_PICK05] ? line_i[5] : line_i[0];
   assign src34 = wake_reg[B_PICK34] ? line_i[4] : line_i[3];
   assign ch05 = wake_reg[B_PICK05] ? (line_i[5] != prev_reg[5]) : (line_i[0] != prev_reg[0]);
   assign ch34 = wake_reg[B_PICK34] ? (line_i[4] != prev_reg[4]) : (line_i[3] != prev_reg[3]);
   assign wake_hit = sleep_reg && ((wake_reg[B_WAKE05] && ch05) || (wake_reg[B_WAKE34] && ch34));

   // Wake needs no debouncer clock, since clocks stop in sleep.
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sleep_reg <= 1'b0;
         wake_reg_p <= 1'b0;
         prev_reg <= 6'h00;
      end
      else
      begin
         prev_reg <= line_i;
         wake_reg_p <= wake_hit && !sys_rst;
         if (sys_rst)
            sleep_reg <= 1'b0;
         else if (wake_hit)
            sleep_reg <= 1'b0;
         else if (wr && wb_adr_i == ADR_POWER_CTRL)
            sleep_reg <= wb_dat_i[B_SLEEP];
      end
   end

   assign sleep_o = sleep_reg;
   assign wake_o = wake_reg_p;

   // ------------------------------------------------------------
   // Input blocking and distribution
   // ------------------------------------------------------------

   // A line used for wake, interrupt or reset must stay live in sleep.
   assign used0 = !wake_reg[B_PICK05] && (wake_reg[B_WAKE05] || irq_en_i[0]);
   assign used3 = !wake_reg[B_PICK34] && (wake_reg[B_WAKE34] || irq_en_i[1] || frq_reg[B_EXT_RESET_EN]);
   assign used4 = wake_reg[B_PICK34] && (wake_reg[B_WAKE34] || irq_en_i[1] || frq_reg[B_EXT_RESET_EN]);
   assign blocked_o[0] = sleep_reg && !used0;
   assign blocked_o[1] = sleep_reg;
   assign blocked_o[2] = sleep_reg;
   assign blocked_o[3] = sleep_reg && !used3;
   assign blocked_o[4] = (sleep_reg && !used4) || pwr_reg[B_VCHECK];
   assign blocked_o[5] = 1'b0;
   assign line_in_o = line_i & ~blocked_o;
   assign detector_route_o = pwr_reg[B_VCHECK];
   // Serial slave takes data on line 0 and its clock on line 1.
   assign ser_din_o = line_in_o[0];
   assign ser_sclk_o = !ser_master_i && line_in_o[1];

   // ------------------------------------------------------------
   // Debounced inputs and external reset
   // ------------------------------------------------------------

   pam_debounce u_deb05 (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .tick_i(deb_tick_i),
      .d_i(src05),
      .q_o(q05)
   );

   pam_debounce u_deb34 (
      .mclk_i(mclk_i),
      .resetn_i(resetn_i),
      .tick_i(deb_tick_i),
      .d_i(src34),
      .q_o(q34)
   );

   assign test_var1_o = q05;
   assign test_var2_o = q34;

   // One-cycle reset on a rising debounced edge; sleep has no clocks here.
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         q34_prev_reg <= 1'b0;
         ext_rst_reg <= 1'b0;
      end
      else
      begin
         q34_prev_reg <= q34;
         ext_rst_reg <= q34 && !q34_prev_reg && !sleep_reg && !ext_rst_reg
            && frq_reg[B_EXT_RESET_EN] && frq_reg[B_ACT_RESET_EN];
      end
   end

   assign ext_reset_o = ext_rst_reg;

   // ------------------------------------------------------------
   // Output multiplexing
   // ------------------------------------------------------------

   assign core_clk = ext_clk_sel_i ? line_i[1] : rc_clk_i;
   assign l2sel = pam_l2sel_t'(sel4_reg[1:0]);
   // Strap pattern on the other lines forces line 2 out during system reset while line 2 is set to the reset indicator.
   assign force2 = sys_reset_i && !line_i[0] && line_i[1] && line_i[4]
      && (l2sel == L2_RSTIND);

   // Frequency source for lines 2 and 5.
   always_comb
   begin
      case (frq_reg[1:0])
         FS_CORE: freq_sig = core_clk;
         FS_SYSTEM: freq_sig = sys_clk_i;
         FS_2KHZ: freq_sig = clk_2khz_i;
         default: freq_sig = clk_1hz_i;
      endcase
   end

   // Per-line source choice; line 4 is input only.
   always_comb
   begin
      val_next[0] = sel3_reg[B_PWM0] ? pwm_i : data_reg[0];
      if (sel3_reg[B_SER_CLOCK1])
         val_next[1] = ser_sclk_i;
      else
         val_next[1] = sel3_reg[B_PWM1] ? pwm_i : data_reg[1];
      case (l2sel)
         L2_DATA: val_next[2] = data_reg[2];
         L2_FREQ: val_next[2] = freq_sig;
         L2_SOUT: val_next[2] = ser_dout_i;
         default: val_next[2] = sys_reset_i || (!sleep_reg && clk_8khz_i);
      endcase
      val_next[3] = sel3_reg[B_SER_STATUS3] ? ser_status_i : data_reg[3];
      val_next[4] = 1'b0;
      val_next[5] = sel4_reg[B_FREQ5] ? freq_sig : data5_reg;
      oe_next = {oe5_reg, 1'b0, oe_reg[3], oe_reg[2] || force2, oe_reg[1:0]};
   end

   // Pin requests are registered so the pads never see decode glitches.
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         pad_bus.val <= 6'h00;
         pad_bus.oe <= 6'h00;
      end
      else
      begin
         pad_bus.val <= val_next;
         pad_bus.oe <= oe_next;
      end
   end

   assign pad_bus.od = {od5_reg, 1'b0, od_reg};
   assign pad_bus.pd_off = {sel4_reg[B_NOPD5], pwr_reg[B_NOPULL4], nopd_reg};

   pam_pad_drv u_pad (
      .pad(pad_bus.pad),
      .line_o(line_o),
      .line_oe_o(line_oe_o),
      .pullup_o(pullup_o),
      .pulldown_o(pulldown_o)
   );

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);

   a_vcheck_read_zero: assert property (pwr_reg[B_VCHECK] |-> !line_in_o[4])
      else $error("line 4 visible during voltage check");
   a_line5_never_blocked: assert property (!blocked_o[5] && line_in_o[5] == line_i[5])
      else $error("line 5 blocked");
   a_sleep_blocks_mid: assert property (sleep_reg |-> blocked_o[1] && blocked_o[2])
      else $error("line 1 or 2 open in sleep");
   a_reset_ends_sleep: assert property (sys_rst |=> !sleep_reg && oe_reg == 4'h0)
      else $error("reset left sleep or outputs");
   a_por_bits_kept: assert property (sys_rst && !wr |=> $stable(nopd_reg) && $stable(od_reg))
      else $error("power-on-only bits changed");
   a_ext_reset_gate: assert property (ext_rst_reg |-> $past(frq_reg[3:2]) == 2'h3)
      else $error("pin reset without enables");
   a_wake_exit: assert property (wake_hit && !sys_rst |=> !sleep_reg && wake_o)
      else $error("wake change ignored");
   a_od_low_only: assert property (od_reg[0] && line_oe_o[0] |-> !line_o[0])
      else $error("open drain drove high");
   a_line0_follows: assert property (oe_reg[0] && !sys_rst
      |=> line_oe_o[0] == !(pad_bus.od[0] && pad_bus.val[0]))
      else $error("line 0 enable not applied");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");
endmodule
`default_nettype wire

// ---- sim/pam_pins.sv ----
// Board wiring outside the six pins: port drive, a bench source and the pulls.
// Assumes the port drives only where its enable is high.
`timescale 1ns/100ps
`default_nettype none
module pam_pins (
   // Port side
   input wire logic mclk_i,
   input wire logic [5:0] line_o,
   input wire logic [5:0] line_oe_o,
   input wire logic [5:0] pullup_o,
   input wire logic [5:0] pulldown_o,
   // Bench source and resolved level
   input wire logic [5:0] ext_en_i,
   input wire logic [5:0] ext_val_i,
   output logic [5:0] level_o
);
   logic [5:0] flt_reg = 6'h2a;
   // An open pin flips each cycle, so a stale level never passes for a real one.
   always @(posedge mclk_i)
      flt_reg <= ~flt_reg;
   // Port drive wins, then the bench source, then a pull, else the pin floats.
   assign level_o = line_oe_o & line_o | ~line_oe_o & (ext_en_i & ext_val_i |
      ~ext_en_i & (pullup_o | ~pulldown_o & flt_reg));
endmodule
`default_nettype wire

// ---- sim/port_a_io_mux_test.sv ----
// Bench for the six-line port: registers, resets, output selection, sleep, wake,
// voltage check and pin reset. Assumes pam_pins stands for the board.
`timescale 1ns/100ps
`default_nettype none
module port_a_io_mux_test;
   import pam_pkg::*;
   typedef struct packed {logic [7:0] a; logic [3:0] r, d, e, k;} pam_row_t;
   // Design inputs, each with a value at time zero except line_i, which the pins drive.
   logic mclk_i = 0, resetn_i = 0, sys_reset_i = 0, deb_tick_i = 0, wb_cyc_i = 0;
   logic wb_stb_i = 0, wb_we_i = 0, ser_master_i = 0, ser_dout_i = 0, ser_sclk_i = 0;
   logic ser_status_i = 0, pwm_i = 0, rc_clk_i = 0, ext_clk_sel_i = 0, sys_clk_i = 0;
   logic clk_2khz_i = 0, clk_1hz_i = 0, clk_8khz_i = 0;
   logic [1:0] irq_en_i = 2'h0;
   logic [3:0] wb_sel_i = 4'h1;
   logic [7:0] wb_adr_i = 8'h00;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic [5:0] line_i, ext_en = 6'h00, ext_val = 6'h00;
   // Design outputs.
   logic wb_ack_o, ser_din_o, ser_sclk_o, test_var1_o, test_var2_o, detector_route_o;
   logic ext_reset_o, sleep_o, wake_o;
   logic [5:0] line_o, line_oe_o, pullup_o, pulldown_o, line_in_o, blocked_o;
   int n_errors = 0, checked = 0, cycles = 0;
   // Address, reset value, write, readback, value after a system reset.
   pam_row_t rows [8] = '{24'h040880, 24'h080aaa, 24'h0c0999, 24'h140222, 24'h180aa0,
      24'h1c3333, 24'h200330, 24'h3c0f00};

   pam_port_a_io_mux DUT (.mclk_i, .resetn_i, .sys_reset_i, .wb_cyc_i, .wb_stb_i,
      .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .line_i, .line_o,
      .line_oe_o, .pullup_o, .pulldown_o, .deb_tick_i, .irq_en_i, .ser_master_i,
      .ser_dout_i, .ser_sclk_i, .ser_status_i, .pwm_i, .rc_clk_i, .ext_clk_sel_i,
      .sys_clk_i, .clk_2khz_i, .clk_1hz_i, .clk_8khz_i, .line_in_o, .blocked_o,
      .ser_din_o, .ser_sclk_o, .test_var1_o, .test_var2_o, .detector_route_o,
      .ext_reset_o, .sleep_o, .wake_o);
   pam_pins pins (.mclk_i, .line_o, .line_oe_o, .pullup_o, .pulldown_o,
      .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(line_i));

   // Clock of 8 ns period.
   always #4 mclk_i = ~mclk_i;
   // Debouncer tick every fourth cycle; the tests need under 1500 cycles.
   always @(posedge mclk_i)
   begin
      cycles <= cycles + 1;
      deb_tick_i <= (cycles[1:0] == 2'h0);
      if (cycles == 5000)
      begin
         n_errors++;
         report_and_stop();
      end
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // One classic cycle held to the ack edge; a read compares with d.
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] d);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, 28'h0, d};
      @(posedge mclk_i);
      repeat (20) if (wb_ack_o !== 1'h1) @(posedge mclk_i);
      chk(wb_ack_o, 1'h1);
      if (!w)
         chk(wb_dat_o[3:0], d);
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      repeat (2) @(posedge mclk_i);
   endtask
   // Bounded wait for a level or a one-cycle pulse.
   task automatic hi(ref logic s);
      repeat (60) if (s !== 1'h1) @(posedge mclk_i);
      chk(s, 1'h1);
   endtask
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      repeat (2) @(posedge mclk_i);
      resetn_i <= 1'h1;
      @(posedge mclk_i);
      chk(line_oe_o, 6'h00);
      chk(pulldown_o, 6'h3f);
      chk(pullup_o, 6'h00);
      foreach (rows[i])
         wb(1'h0, rows[i].a, rows[i].r);
      foreach (rows[i])
      begin
         wb(1'h1, rows[i].a, rows[i].d);
         wb(1'h0, rows[i].a, rows[i].e);
      end
      // Strap levels on lines 0, 1 and 4 with line 2 select 11.
      {ext_en, ext_val} <= 12'h4d2;
      sys_reset_i <= 1'h1;
      repeat (3) @(posedge mclk_i);
      chk(line_oe_o[2], 1'h1);
      sys_reset_i <= 1'h0;
      repeat (3) @(posedge mclk_i);
      chk(line_oe_o, 6'h00);
      foreach (rows[i])
         wb(1'h0, rows[i].a, rows[i].k);
      $display("done: registers and resets");
      // Every low line an output fed by its peripheral source.
      ext_en <= 6'h00;
      wb(1'h1, 8'h04, 4'hf);
      wb(1'h1, 8'h0c, 4'h0);
      wb(1'h1, 8'h18, 4'hd);
      wb(1'h1, 8'h1c, 4'h2);
      {pwm_i, ser_sclk_i, ser_dout_i, ser_status_i} <= 4'hf;
      repeat (2) @(posedge mclk_i);
      chk(line_o[3:0], 4'hf);
      chk(pulldown_o[3:0], 4'h0);
      {pwm_i, ser_sclk_i, ser_dout_i, ser_status_i} <= 4'h0;
      wb(1'h1, 8'h00, 4'hf);
      chk(line_o[3:0], 4'h0);
      wb(1'h1, 8'h18, 4'h0);
      wb(1'h1, 8'h1c, 4'h0);
      chk(line_o[3:0], 4'hf);
      wb(1'h0, 8'h00, 4'hf);
      wb(1'h1, 8'h0c, 4'hf);
      chk(line_i[3:0], 4'hf);
      wb(1'h1, 8'h00, 4'h0);
      chk(line_i[3:0], 4'h0);
      wb(1'h1, 8'h04, 4'h0);
      // Line 5 carries each frequency source in turn.
      wb(1'h1, 8'h10, 4'h4);
      wb(1'h1, 8'h1c, 4'h4);
      for (int k = 0; k < 4; k++)
      begin
         wb(1'h1, 8'h14, k[3:0]);
         {rc_clk_i, sys_clk_i, clk_2khz_i, clk_1hz_i} <= 4'h1 << k;
         repeat (2) @(posedge mclk_i);
         chk(line_o[5], 1'h1);
         {rc_clk_i, sys_clk_i, clk_2khz_i, clk_1hz_i} <= ~(4'h1 << k);
         repeat (2) @(posedge mclk_i);
         chk(line_o[5], 1'h0);
      end
      // External clock: core clock follows the pulled-up line 1, not the idle RC clock.
      ext_clk_sel_i <= 1'h1;
      repeat (2) @(posedge mclk_i);
      chk(line_o[5], 1'h1);
      ext_clk_sel_i <= 1'h0;
      wb(1'h1, 8'h10, 4'h0);
      $display("done: output selection");
      // Sleep with all pins driven high, then wake on line 3.
      {ext_en, ext_val} <= 12'hfff;
      wb(1'h1, 8'h24, 4'h1);
      chk(blocked_o, 6'h1f);
      chk(line_in_o, 6'h20);
      wb(1'h1, 8'h20, 4'h8);
      chk(blocked_o, 6'h17);
      wb(1'h0, 8'h14, 4'h3);
      ext_val <= 6'h37;
      hi(wake_o);
      chk(sleep_o, 1'h0);
      chk(ser_din_o, 1'h1);
      chk(ser_sclk_o, 1'h1);
      chk(test_var1_o, 1'h1);
      ser_master_i <= 1'h1;
      @(posedge mclk_i);
      chk(ser_sclk_o, 1'h0);
      ser_master_i <= 1'h0;
      wb(1'h1, 8'h24, 4'h6);
      chk(detector_route_o, 1'h1);
      chk(blocked_o[4], 1'h1);
      wb(1'h0, 8'h10, 4'h2);
      wb(1'h1, 8'h24, 4'h0);
      // Debounced rise on line 4 picked as the reset pin.
      ext_val <= 6'h27;
      wb(1'h1, 8'h04, 4'h1);
      wb(1'h1, 8'h20, 4'h2);
      wb(1'h1, 8'h14, 4'hc);
      repeat (20) @(posedge mclk_i);
      ext_val <= 6'h37;
      hi(ext_reset_o);
      repeat (2) @(posedge mclk_i);
      wb(1'h0, 8'h04, 4'h0);
      chk(test_var2_o, 1'h1);
      $display("done: sleep, wake and pin reset");
      report_and_stop();
   end
endmodule
`default_nettype wire
